// [verilog/flo_exec.sv]
// flo_exec: executes flag, bit-transfer, move and load ops from a command.
// assumes: Avalon-MM master holds requests; data memory answers one cycle
// after its read strobe.
`timescale 1ns/100ps
`default_nettype none
module flo_exec
  import flo_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output flo_dmem_req_s    dmem_req_out,
  input  wire logic [7:0]  dmem_rdata_in
);

  flo_state_e    state_reg, state_next;
  logic          ack_reg;
  logic [31:0]   rdata_reg;
  logic [7:0]    flags_reg, flags_next;
  logic [3:0]    last_op_reg;
  flo_instr_s    cur_reg;
  flo_dmem_req_s dmem_req_reg;
  logic [15:0]   ptr_new_reg;
  flo_rf_t       rf;
  logic          a_we, b_we;
  logic [4:0]    a_idx;
  logic [7:0]    a_data;
  logic [3:0]    b_pair;
  logic [15:0]   b_data;

  function automatic logic [3:0] ptr_pair(input flo_ptr_e sel);
    ptr_pair = (sel == ptr_x) ? X_PAIR : (sel == ptr_y) ? Y_PAIR : Z_PAIR;
  endfunction

  function automatic logic [15:0] ptr_of(input flo_rf_t f,
                                         input flo_ptr_e sel);
    logic [3:0] p;
    p = ptr_pair(sel);
    ptr_of = {f[{p, 1'b1}], f[{p, 1'b0}]};
  endfunction

  function automatic logic is_wreg(input logic [7:0] a);
    is_wreg = (a[7] == WREG_BASE[7]) && (a[1:0] == 2'b00);
  endfunction

  // bus decode; one wait cycle so read data comes from a flop
  wire logic       req      = avs_read_in | avs_write_in;
  wire logic       idle     = (state_reg == st_idle);
  wire logic       take     = req & ~ack_reg & idle;
  wire logic       wr_done  = avs_write_in & ack_reg;
  wire logic       hit_cmd  = (avs_address_in == CMD_OFS);
  wire logic       hit_flg  = (avs_address_in == FLAGS_OFS);
  wire logic       hit_stat = (avs_address_in == STATUS_OFS);
  wire logic       hit_wreg = is_wreg(avs_address_in);
  wire logic [4:0] wreg_idx = avs_address_in[6:2];
  wire logic       be_low   = avs_byteenable_in[0];
  wire logic       cmd_go   = wr_done & hit_cmd &
                              (avs_byteenable_in == BE_ALL);
  wire flo_instr_s ins      = flo_instr_s'(avs_writedata_in);

  assign avs_waitrequest_out = req & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;
  assign dmem_req_out        = dmem_req_reg;

  // operands of the command being written; pointer math uses the latched command
  wire logic [7:0]  src_byte = rf[ins.rr];
  wire logic [7:0]  dst_byte = rf[ins.rd];
  wire logic        src_bit  = src_byte[ins.bitsel];
  wire logic [15:0] ptr_cur  = ptr_of(rf, cur_reg.ptr);
  wire logic [15:0] ptr_dec  = ptr_cur - PTR_STEP;
  wire logic [15:0] ptr_inc  = ptr_cur + PTR_STEP;
  wire logic        pre_dec  = (cur_reg.mode == mode_pre_dec);
  wire logic [15:0] rd_addr  = pre_dec ? ptr_dec : ptr_cur;
  wire logic [15:0] ptr_upd  = pre_dec ? ptr_dec : ptr_inc;

  // read mux; values are stable between take and the answer edge
  wire logic [31:0] stat_word = {24'h000000, last_op_reg, 3'b000, ~idle};
  wire logic [31:0] rd_mux =
    hit_cmd  ? 32'(cur_reg) :
    hit_flg  ? {24'h000000, flags_reg} :
    hit_stat ? stat_word :
    hit_wreg ? {24'h000000, rf[wreg_idx]} : UNMAPPED_RDATA;

  // flag updates; direct software writes take priority over ops
  always_comb begin
    flags_next = flags_reg;
    if (wr_done && hit_flg && be_low) begin
      flags_next = avs_writedata_in[7:0];
    end else if (cmd_go) begin
      unique case (ins.op)
        bit_store_to_flag:   flags_next[FLG_T] = src_bit;
        set_overflow_op:     flags_next[FLG_V] = 1'b1;
        clear_overflow_op:   flags_next[FLG_V] = 1'b0;
        set_sign_op:         flags_next[FLG_S] = 1'b1;
        clear_sign_op:       flags_next[FLG_S] = 1'b0;
        clear_half_carry_op: flags_next[FLG_H] = 1'b0;
        flag_set_op:         flags_next[ins.bitsel] = 1'b1;
        flag_clear_op:       flags_next[ins.bitsel] = 1'b0;
        default: ;
      endcase
    end
  end

  // register file write ports; flag ops leave both ports idle
  always_comb begin
    a_we   = 1'b0;
    a_idx  = ins.rd;
    a_data = src_byte;
    b_we   = 1'b0;
    b_pair = ins.rd[4:1];
    b_data = {rf[{ins.rr[4:1], 1'b1}], rf[{ins.rr[4:1], 1'b0}]};
    if (state_reg == st_data) begin
      a_we   = 1'b1;
      a_idx  = cur_reg.rd;
      a_data = dmem_rdata_in;
      b_we   = (cur_reg.mode == mode_post_inc) || pre_dec;
      b_pair = ptr_pair(cur_reg.ptr);
      b_data = ptr_new_reg;
    end else if (wr_done && hit_wreg && be_low) begin
      a_we   = 1'b1;
      a_idx  = wreg_idx;
      a_data = avs_writedata_in[7:0];
    end else if (cmd_go) begin
      unique case (ins.op)
        bit_load_from_flag: begin
          a_we = 1'b1;
          a_data = dst_byte;
          a_data[ins.bitsel] = flags_reg[FLG_T];
        end
        move_op: a_we = 1'b1;
        load_imm_op: begin
          a_we = 1'b1;
          a_data = ins.imm;
        end
        move_word_op: b_we = 1'b1;
        default: ;
      endcase
    end
  end

  // load sequencer; the bus stalls outside idle so pointers hold still
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_idle: if (cmd_go && ins.op == indirect_load_op) state_next = st_addr;
      st_addr: state_next = st_wait;
      st_wait: state_next = st_data;
      st_data: state_next = st_idle;
    endcase
  end

  flo_regfile u_regfile (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .a_we_in   (a_we),
    .a_idx_in  (a_idx),
    .a_data_in (a_data),
    .b_we_in   (b_we),
    .b_pair_in (b_pair),
    .b_data_in (b_data),
    .rf_out    (rf)
  );

  // bus handshake and read data
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= UNMAPPED_RDATA;
    end else begin
      ack_reg <= take;
      if (take) rdata_reg <= rd_mux;
    end
  end

  // state, flags, last command
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_reg   <= st_idle;
      flags_reg   <= FLAGS_RST;
      last_op_reg <= nop_op;
      cur_reg     <= '0;
    end else begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      if (cmd_go) begin
        last_op_reg <= ins.op;
        cur_reg     <= ins;
      end
    end
  end

  // memory request: strobe for one cycle in st_wait, address to st_data
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      dmem_req_reg <= '0;
      ptr_new_reg  <= 16'h0000;
    end else if (state_reg == st_addr) begin
      dmem_req_reg <= '{addr: rd_addr, rd: 1'b1};
      ptr_new_reg  <= ptr_upd;
    end else begin
      dmem_req_reg.rd <= 1'b0;
    end
  end

  // helper state that only the checks below read
  flo_instr_s  chk_ins_reg;
  flo_rf_t     chk_rf_reg;
  logic [7:0]  chk_flags_reg;
  logic [15:0] chk_ptr_reg;
  logic [7:0]  chk_data_reg;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      chk_ins_reg   <= '0;
      chk_rf_reg    <= '0;
      chk_flags_reg <= 8'h00;
      chk_ptr_reg   <= 16'h0000;
      chk_data_reg  <= 8'h00;
    end else begin
      if (cmd_go) begin
        chk_ins_reg   <= ins;
        chk_rf_reg    <= rf;
        chk_flags_reg <= flags_reg;
        chk_ptr_reg   <= ptr_of(rf, ins.ptr);
      end
      if (state_reg == st_data) chk_data_reg <= dmem_rdata_in;
    end
  end
  wire logic ptr_clash = (ins.rd[4:1] == ptr_pair(ins.ptr));
  wire logic one_flag  = (ins.op >= set_overflow_op) &&
                         (ins.op <= clear_half_carry_op);
  // the one flag a single-flag op may touch; a wrong target must fire
  wire logic [7:0] chk_own_bit =
    (chk_ins_reg.op inside {set_overflow_op, clear_overflow_op}) ?
      (8'h01 << FLG_V) :
    (chk_ins_reg.op inside {set_sign_op, clear_sign_op}) ?
      (8'h01 << FLG_S) : (8'h01 << FLG_H);

  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  chk_bit_store_t: assert property (
    cmd_go && ins.op == bit_store_to_flag |=>
      flags_reg[FLG_T] == $past(src_bit) && rf == chk_rf_reg)
    else $error("bit store did not copy the source bit into T");
  chk_bit_load_rd: assert property (
    cmd_go && ins.op == bit_load_from_flag |=>
      rf[chk_ins_reg.rd][chk_ins_reg.bitsel] == chk_flags_reg[FLG_T] &&
      ((rf[chk_ins_reg.rd] ^ chk_rf_reg[chk_ins_reg.rd]) &
       ~(8'h01 << chk_ins_reg.bitsel)) == 8'h00)
    else $error("bit load wrong bit or disturbed other bits");
  chk_set_overflow: assert property (
    cmd_go && ins.op == set_overflow_op |=> flags_reg[FLG_V])
    else $error("overflow flag not set");
  chk_clear_overflow: assert property (
    cmd_go && ins.op == clear_overflow_op |-> ##1 $past(cmd_go) ##0
      !flags_reg[FLG_V])
    else $error("overflow flag not cleared");
  chk_set_sign: assert property (
    cmd_go && ins.op == set_sign_op |=> flags_reg[FLG_S] == 1'b1)
    else $error("sign flag not set");
  chk_clear_sign: assert property (
    cmd_go && ins.op == clear_sign_op |=> !flags_reg[FLG_S])
    else $error("sign flag not cleared");
  chk_clear_half: assert property (
    cmd_go && ins.op == clear_half_carry_op |=> flags_reg[FLG_H] == 1'b0)
    else $error("half carry flag not cleared");
  chk_post_inc_load: assert property (
    cmd_go && ins.op == indirect_load_op && ins.mode == mode_post_inc &&
    !ptr_clash |-> ##2 (dmem_req_out.rd && dmem_req_out.addr == chk_ptr_reg)
      ##2 (rf[chk_ins_reg.rd] == chk_data_reg &&
           ptr_of(rf, chk_ins_reg.ptr) == chk_ptr_reg + PTR_STEP))
    else $error("post-increment load address, data or pointer wrong");
  chk_pre_dec_load: assert property (
    cmd_go && ins.op == indirect_load_op && ins.mode == mode_pre_dec &&
    !ptr_clash |-> ##2 (dmem_req_out.rd &&
      dmem_req_out.addr == chk_ptr_reg - PTR_STEP)
      ##2 (rf[chk_ins_reg.rd] == chk_data_reg &&
           ptr_of(rf, chk_ins_reg.ptr) == chk_ptr_reg - PTR_STEP))
    else $error("pre-decrement load address, data or pointer wrong");
  chk_one_flag_only: assert property (
    cmd_go && one_flag |=> rf == chk_rf_reg &&
      ((flags_reg ^ chk_flags_reg) & ~chk_own_bit) == 8'h00)
    else $error("single-flag op changed more than its flag");

endmodule
`default_nettype wire

// [verilog/flo_pkg.sv]
// flo_pkg: constants, types and register map of the flag/bit/load executor.
// assumes: one core clock, synchronous active-low reset, Avalon-MM slave.
// Notes on behaviour
// - bit store copies chosen bit of source register into T flag only.
// - bit load writes T into chosen bit of destination, other bits kept.
// - set-overflow op forces the V flag to one.
// - clear-overflow op forces the V flag to zero.
// - set-sign op drives the S flag to one.
// - clear-sign op drives the S flag to zero.
// - clear-half-carry op drives the H flag to zero.
// - post-increment load reads byte at pointer, then pointer grows by one.
// - pre-decrement load lowers pointer by one, then reads at new value.
package flo_pkg;

  // register map, byte addresses
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] FLAGS_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] WREG_BASE  = 8'h80; // 32 words, one per register

  // reset values, unmapped read data and the full byte-enable mask
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [7:0]  WREG_RST  = 8'h00;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;
  localparam logic [3:0]  BE_ALL    = 4'hf;

  // flag register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // status register fields
  localparam int STAT_BUSY   = 0;
  localparam int STAT_OP_LSB = 4;

  // pointer pairs as register-pair indices (low byte at even index)
  localparam logic [3:0] X_PAIR = 4'hd;
  localparam logic [3:0] Y_PAIR = 4'he;
  localparam logic [3:0] Z_PAIR = 4'hf;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  typedef enum logic [3:0] {
    nop_op              = 4'h0,
    bit_store_to_flag   = 4'h1,
    bit_load_from_flag  = 4'h2,
    set_overflow_op     = 4'h3,
    clear_overflow_op   = 4'h4,
    set_sign_op         = 4'h5,
    clear_sign_op       = 4'h6,
    clear_half_carry_op = 4'h7,
    flag_set_op         = 4'h8,
    flag_clear_op       = 4'h9,
    move_op             = 4'ha,
    move_word_op        = 4'hb,
    load_imm_op         = 4'hc,
    indirect_load_op    = 4'hd
  } flo_op_e;

  typedef enum logic [1:0] {
    mode_plain    = 2'h0,
    mode_post_inc = 2'h1,
    mode_pre_dec  = 2'h2,
    mode_spare    = 2'h3
  } flo_mode_e;

  typedef enum logic [1:0] {
    ptr_x = 2'h0,
    ptr_y = 2'h1,
    ptr_z = 2'h2,
    ptr_r = 2'h3
  } flo_ptr_e;

  // gray along idle -> addr -> wait -> data -> idle
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_addr = 2'h1,
    st_wait = 2'h3,
    st_data = 2'h2
  } flo_state_e;

  // instruction word as written to the command register
  typedef struct packed {
    logic [2:0] spare;
    logic [7:0] imm;
    flo_mode_e  mode;
    flo_ptr_e   ptr;
    logic [2:0] bitsel;
    logic [4:0] rr;
    logic [4:0] rd;
    flo_op_e    op;
  } flo_instr_s;

  // data memory read request
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
  } flo_dmem_req_s;

  typedef logic [31:0][7:0] flo_rf_t;

endpackage

// [verilog/flo_regfile.sv]
// flo_regfile: 32 working registers of eight bits in flip-flops.
// assumes: at most one byte write and one pair write per cycle.
`timescale 1ns/100ps
`default_nettype none
module flo_regfile
  import flo_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        a_we_in,
  input  wire logic [4:0]  a_idx_in,
  input  wire logic [7:0]  a_data_in,
  input  wire logic        b_we_in,
  input  wire logic [3:0]  b_pair_in,
  input  wire logic [15:0] b_data_in,
  output flo_rf_t          rf_out
);

  // byte port wins over pair port on the same register
  for (genvar i = 0; i < 32; i++) begin : g_reg
    logic [7:0] byte_reg;
    always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
        byte_reg <= WREG_RST;
      end else if (a_we_in && a_idx_in == 5'(i)) begin
        byte_reg <= a_data_in;
      end else if (b_we_in && b_pair_in == 4'(i / 2)) begin
        byte_reg <= b_data_in[8 * (i % 2) +: 8];
      end
    end
    assign rf_out[i] = byte_reg;
  end

endmodule
`default_nettype wire

// [tb/tb.sv]
// tb: self-checking bench for flo_exec, register bus and data memory side.
// assumes: flo_pkg register map; memory byte is a fixed function of address.
`timescale 1ns/100ps
`default_nettype none
module tb
  import flo_pkg::*;
();
  logic          clock_in = 1'b0;
  logic          nrst_in = 1'b0;
  logic [7:0]    avs_address_in = 8'h00;
  logic          avs_read_in = 1'b0;
  logic          avs_write_in = 1'b0;
  logic [3:0]    avs_byteenable_in = BE_ALL;
  logic [31:0]   avs_writedata_in = 32'h0;
  logic [31:0]   avs_readdata_out;
  logic          avs_waitrequest_out;
  flo_dmem_req_s dmem_req_out;
  logic [7:0]    dmem_rdata_in = 8'h00;
  logic [15:0]   last_addr = 16'h0;
  int            n_errors = 0;
  int            num_checks = 0;
  logic [31:0]   q;

  flo_exec i_dut (
    .clock_in            (clock_in),
    .nrst_in             (nrst_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .dmem_req_out        (dmem_req_out),
    .dmem_rdata_in       (dmem_rdata_in)
  );

  // clock; time-zero values sit in the declarations, one driver each
  always #20 clock_in = ~clock_in;

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // memory answers in the cycle after rd; otherwise the line wanders,
  // so a design sampling at the wrong edge sees a wrong byte
  always @(posedge clock_in) begin
    if (dmem_req_out.rd === 1'b1) begin
      dmem_rdata_in <= mem_byte(dmem_req_out.addr);
      last_addr <= dmem_req_out.addr;
    end else begin
      dmem_rdata_in <= ~dmem_rdata_in;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one Avalon access, held until the rising edge that sees waitrequest
  // low; data taken and request dropped at that edge, a hang is left to
  // the watchdog
  task automatic bus(input logic is_wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= ~is_wr;
    avs_write_in <= is_wr;
    do begin
      @(posedge clock_in);
    end while (avs_waitrequest_out !== 1'b0);
    rq = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string msg);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e, msg);
  endtask

  function automatic logic [7:0] wa(input int n);
    return WREG_BASE + 8'(4 * n);
  endfunction

  function automatic logic [31:0] cmd(input flo_op_e op, input int d,
    input int b, input flo_ptr_e p, input flo_mode_e m);
    flo_instr_s c;
    c = '0;
    c.op = op;
    c.rd = 5'(d);
    c.rr = 5'(d);
    c.bitsel = 3'(b);
    c.ptr = p;
    c.mode = m;
    return c;
  endfunction

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #(40 * 20000);
    n_errors++;
    results();
  end

  flo_op_e     f_op [5] = '{set_overflow_op, clear_overflow_op, set_sign_op,
                            clear_sign_op, clear_half_carry_op};
  int          f_bit[5] = '{FLG_V, FLG_V, FLG_S, FLG_S, FLG_H};
  logic        f_val[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  flo_ptr_e    l_ptr[3] = '{ptr_x, ptr_y, ptr_z};
  flo_mode_e   l_md [3] = '{mode_post_inc, mode_pre_dec, mode_pre_dec};
  logic [15:0] l_val[3] = '{16'h12ff, 16'h3400, 16'h0001};

  initial begin
    logic [7:0]  e;
    logic [15:0] p;
    logic [15:0] a;
    flo_instr_s  ci;
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    // reset values and an unmapped place
    rd_chk(FLAGS_OFS, {24'h0, FLAGS_RST}, "flags reset");
    rd_chk(STATUS_OFS, 32'h0, "status reset");
    rd_chk(wa(9), {24'h0, WREG_RST}, "wreg reset");
    rd_chk(8'h0c, UNMAPPED_RDATA, "unmapped read");
    $display("test reset done");

    // single-flag ops from both all-zero and all-one starting flags
    wr(wa(1), 32'h0000_005a);
    for (int i = 0; i < 10; i++) begin
      e = (i % 2 == 1) ? 8'hff : 8'h00;
      wr(FLAGS_OFS, {24'h0, e});
      wr(CMD_OFS, cmd(f_op[i / 2], 1, 0, ptr_x, mode_plain));
      e[f_bit[i / 2]] = f_val[i / 2];
      q = {24'h0, e};
      if (i < 4) begin
        rd_chk(FLAGS_OFS, q, "v op");
      end else if (i < 8) begin
        rd_chk(FLAGS_OFS, q, "s op");
      end else begin
        rd_chk(FLAGS_OFS, q, "h op");
      end
      rd_chk(wa(1), 32'h0000_005a, "flag op reg");
    end
    $display("test flag ops done");

    // bit store: T takes each bit, the opposite T preset each time
    wr(wa(5), 32'h0000_00a5);
    for (int b = 0; b < 8; b++) begin
      e = ((8'ha5 >> b) & 8'h01) ? 8'h00 : 8'hff;
      wr(FLAGS_OFS, {24'h0, e});
      wr(CMD_OFS, cmd(bit_store_to_flag, 5, b, ptr_x, mode_plain));
      e[FLG_T] = ~e[FLG_T];
      rd_chk(FLAGS_OFS, {24'h0, e}, "bit store flags");
      rd_chk(wa(5), 32'h0000_00a5, "bit store reg");
    end
    $display("test bit store done");

    // bit load: T one into the even bits of 8'h3c, T zero into the odd bits
    for (int b = 0; b < 8; b++) begin
      wr(wa(7), 32'h0000_003c);
      e = (b % 2 == 0) ? 8'h40 : 8'h00;
      wr(FLAGS_OFS, {24'h0, e});
      wr(CMD_OFS, cmd(bit_load_from_flag, 7, b, ptr_x, mode_plain));
      e = 8'h3c;
      e[b] = (b % 2 == 0);
      rd_chk(wa(7), {24'h0, e}, "bit load");
    end
    $display("test bit load done");

    // indirect loads; first read right after the command stalls the bus
    for (int i = 0; i < 3; i++) begin
      wr(wa(26 + 2 * i), {24'h0, l_val[i][7:0]});
      wr(wa(27 + 2 * i), {24'h0, l_val[i][15:8]});
      wr(CMD_OFS, cmd(indirect_load_op, 3 + i, 0, l_ptr[i], l_md[i]));
      a = (l_md[i] == mode_post_inc) ? l_val[i] : l_val[i] - PTR_STEP;
      p = (l_md[i] == mode_post_inc) ? l_val[i] + PTR_STEP : a;
      rd_chk(wa(3 + i), {24'h0, mem_byte(a)}, "load data");
      check({16'h0, last_addr}, {16'h0, a}, "load address");
      rd_chk(wa(26 + 2 * i), {24'h0, p[7:0]}, "ptr low");
      rd_chk(wa(27 + 2 * i), {24'h0, p[15:8]}, "ptr high");
    end
    $display("test indirect load done");

    // remaining decoded ops: immediate, moves, flag by index, plain load
    ci = flo_instr_s'(cmd(load_imm_op, 9, 0, ptr_x, mode_plain));
    ci.imm = 8'hc3;
    wr(CMD_OFS, ci);
    rd_chk(wa(9), 32'h0000_00c3, "load imm");
    ci = flo_instr_s'(cmd(move_op, 10, 0, ptr_x, mode_plain));
    ci.rr = 5'd9;
    wr(CMD_OFS, ci);
    rd_chk(wa(10), 32'h0000_00c3, "move");
    wr(wa(8), 32'h0000_005a);
    ci = flo_instr_s'(cmd(move_word_op, 12, 0, ptr_x, mode_plain));
    ci.rr = 5'd8;
    wr(CMD_OFS, ci);
    rd_chk(wa(12), 32'h0000_005a, "move word low");
    rd_chk(wa(13), 32'h0000_00c3, "move word high");
    wr(FLAGS_OFS, 32'h0);
    wr(CMD_OFS, cmd(flag_set_op, 0, FLG_I, ptr_x, mode_plain));
    rd_chk(FLAGS_OFS, 32'h0000_0080, "flag set by index");
    wr(CMD_OFS, cmd(flag_clear_op, 0, FLG_I, ptr_x, mode_plain));
    rd_chk(FLAGS_OFS, 32'h0, "flag clear by index");
    // x was left at 16'h1300 by the post-increment load above
    q = cmd(indirect_load_op, 14, 0, ptr_x, mode_plain);
    wr(CMD_OFS, q);
    rd_chk(wa(14), {24'h0, mem_byte(16'h1300)}, "plain load");
    check({16'h0, last_addr}, 32'h0000_1300, "plain load address");
    rd_chk(wa(26), 32'h0, "plain load ptr low");
    rd_chk(wa(27), 32'h0000_0013, "plain load ptr high");
    rd_chk(CMD_OFS, q, "cmd readback");
    rd_chk(STATUS_OFS, {24'h0, indirect_load_op, 4'h0}, "status op");
    $display("test other ops done");
    results();
  end
endmodule
`default_nettype wire
